// ===== hdl/kwi_pkg.sv
// What this block does
// - eight enable bits, bit n lets port zero pin n raise the keypad interrupt
// - shared key_press_flag sets when an enabled pin is low and function is active
// - interrupt request from the flag only when the keypad source is enabled
// - key_press_flag stays set until software clears it; the handler must clear it
// - an enabled keypad event wakes the processor from idle and from power down
// - any single pin or all pins may be selected; all combine into one interrupt
//
// package for the keypad wake interrupt: register map, field positions, resets
// assumes a simple strobe register port with read data one cycle after the read
package kwi_pkg;

  // sizes
  localparam int KWI_PINS = 8;
  localparam int KWI_AW = 8;
  localparam int KWI_DW = 32;

  // register byte addresses
  localparam logic [KWI_AW-1:0] KWI_OFS_PIN_EN = 8'h00;
  localparam logic [KWI_AW-1:0] KWI_OFS_CTRL = 8'h04;
  localparam logic [KWI_AW-1:0] KWI_OFS_STATUS = 8'h08;
  localparam logic [KWI_AW-1:0] KWI_OFS_MASK = 8'h0C;
  localparam logic [KWI_AW-1:0] KWI_OFS_CAUSE = 8'h10;
  localparam logic [KWI_AW-1:0] KWI_OFS_PINS = 8'h14;

  // field positions
  localparam int KWI_CTRL_FUNC_EN = 0;
  localparam int KWI_STAT_KEY_FLAG = 0;
  localparam int KWI_MASK_KEY_IE = 0;

  // reset values
  localparam logic [KWI_PINS-1:0] KWI_RST_PIN_EN = 8'h00;
  localparam logic KWI_RST_FUNC_EN = 1'b0;
  localparam logic KWI_RST_FLAG = 1'b0;
  localparam logic KWI_RST_MASK = 1'b0;
  localparam logic [KWI_PINS-1:0] KWI_RST_CAUSE = 8'h00;
  localparam logic [KWI_DW-1:0] KWI_RST_RDATA = 32'h0000_0000;

  // register port request as one bundle
  typedef struct packed {
    logic [KWI_AW-1:0] addr;
    logic [KWI_DW-1:0] wdata;
    logic wr;
    logic rd;
  } kwi_bus_req_t;

  // power states of the core; the wake output serves only idle and down
  typedef enum logic [1:0] {
    KWI_PWR_RUN,
    KWI_PWR_IDLE,
    KWI_PWR_DOWN
  } kwi_pwr_t;

endpackage

// ===== hdl/kwi_wake.sv
// combinational pin qualifier and wake path for the keypad wake interrupt
// assumes port pins are synchronous to ref_clk; works with the clock stopped
`timescale 1ns/10ps
module kwi_wake
#(
  parameter int PINS = 8
)
(
  // pins and settings
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] pin_en,
  input wire logic func_en,
  input wire logic key_ie,
  input wire logic flag,
  // power state
  input wire logic idle_mode,
  input wire logic power_down,
  // results
  output logic [PINS-1:0] pin_hit,
  output logic any_hit,
  output logic wake
);
  import kwi_pkg::*;

  // a pin counts when enabled and pulled low, gated by the global enable
  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1)
    begin : gen_hit
      assign pin_hit[g] = func_en & pin_en[g] & ~pin_in[g];
    end
  endgenerate

  // all selected pins fold into one shared event
  assign any_hit = |pin_hit;

  // wake is not clocked: in power down there is no clock to set the flag first
  assign wake = (idle_mode | power_down) & key_ie & (flag | any_hit);
endmodule

// ===== hdl/kwi_top.sv
// keypad wake interrupt: pin enables, shared flag, mask, interrupt and wake
// assumes pins and register strobes are synchronous to ref_clk
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
module kwi_top
#(
  parameter int PINS = 8
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // register port
  input wire kwi_pkg::kwi_bus_req_t bus_req,
  output logic [kwi_pkg::KWI_DW-1:0] rd_data,
  // keypad pins, port zero
  input wire logic [PINS-1:0] key_pins,
  // power state from the core
  input wire logic idle_mode,
  input wire logic power_down,
  // to the core
  output logic irq,
  output logic wake_req
);
  import kwi_pkg::*;

  // register state
  logic [PINS-1:0] key_pin_enable_r;
  logic [PINS-1:0] key_pin_enable_nxt;
  logic func_en_r;
  logic func_en_nxt;
  logic key_press_flag_r;
  logic key_press_flag_nxt;
  logic key_ie_r;
  logic key_ie_nxt;
  logic [PINS-1:0] cause_r;
  logic [PINS-1:0] cause_nxt;
  logic [KWI_DW-1:0] rd_data_r;
  logic [KWI_DW-1:0] rd_data_nxt;

  // decoded strobes
  logic wr_pin_en;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic wr_cause;

  // wake module outputs
  logic [PINS-1:0] pin_hit;
  logic any_hit;
  logic wake;

  // true when the request address selects the given register
  function automatic logic hit_addr(input logic [KWI_AW-1:0] a, input logic [KWI_AW-1:0] ofs);
    hit_addr = (a == ofs);
  endfunction

  // write strobes per register
  assign wr_pin_en = bus_req.wr & hit_addr(bus_req.addr, KWI_OFS_PIN_EN);
  assign wr_ctrl = bus_req.wr & hit_addr(bus_req.addr, KWI_OFS_CTRL);
  assign wr_status = bus_req.wr & hit_addr(bus_req.addr, KWI_OFS_STATUS);
  assign wr_mask = bus_req.wr & hit_addr(bus_req.addr, KWI_OFS_MASK);
  assign wr_cause = bus_req.wr & hit_addr(bus_req.addr, KWI_OFS_CAUSE);

  // pin qualification and the clockless wake path
  kwi_wake
  #(
    .PINS(PINS)
  )
  u_wake
  (
    .pin_in(key_pins),
    .pin_en(key_pin_enable_r),
    .func_en(func_en_r),
    .key_ie(key_ie_r),
    .flag(key_press_flag_r),
    .idle_mode(idle_mode),
    .power_down(power_down),
    .pin_hit(pin_hit),
    .any_hit(any_hit),
    .wake(wake)
  );

  // configuration next values: enables, global function bit, interrupt mask
  always_comb
  begin
    key_pin_enable_nxt = key_pin_enable_r;
    func_en_nxt = func_en_r;
    key_ie_nxt = key_ie_r;
    if (wr_pin_en)
    begin
      // any combination of pins may be selected
      key_pin_enable_nxt = bus_req.wdata[PINS-1:0];
    end
    if (wr_ctrl)
    begin
      func_en_nxt = bus_req.wdata[KWI_CTRL_FUNC_EN];
    end
    if (wr_mask)
    begin
      key_ie_nxt = bus_req.wdata[KWI_MASK_KEY_IE];
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      key_pin_enable_r <= KWI_RST_PIN_EN;
      func_en_r <= KWI_RST_FUNC_EN;
      key_ie_r <= KWI_RST_MASK;
    end
    else
    begin
      key_pin_enable_r <= key_pin_enable_nxt;
      func_en_r <= func_en_nxt;
      key_ie_r <= key_ie_nxt;
    end
  end

  // flag and cause next values; a new key event beats a write-one clear
  // the flag is level-set: a held key keeps it set, so software must release first
  always_comb
  begin
    key_press_flag_nxt = key_press_flag_r;
    cause_nxt = cause_r;
    if (wr_status && bus_req.wdata[KWI_STAT_KEY_FLAG])
    begin
      key_press_flag_nxt = 1'b0;
    end
    if (wr_cause)
    begin
      cause_nxt = cause_r & ~bus_req.wdata[PINS-1:0];
    end
    if (any_hit)
    begin
      key_press_flag_nxt = 1'b1;
    end
    cause_nxt = cause_nxt | pin_hit;
  end

  // flag and cause registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      key_press_flag_r <= KWI_RST_FLAG;
      cause_r <= KWI_RST_CAUSE;
    end
    else
    begin
      key_press_flag_r <= key_press_flag_nxt;
      cause_r <= cause_nxt;
    end
  end

  // read mux; unmapped addresses and idle cycles return zero
  always_comb
  begin
    rd_data_nxt = KWI_RST_RDATA;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        KWI_OFS_PIN_EN: rd_data_nxt[PINS-1:0] = key_pin_enable_r;
        KWI_OFS_CTRL: rd_data_nxt[KWI_CTRL_FUNC_EN] = func_en_r;
        KWI_OFS_STATUS: rd_data_nxt[KWI_STAT_KEY_FLAG] = key_press_flag_r;
        KWI_OFS_MASK: rd_data_nxt[KWI_MASK_KEY_IE] = key_ie_r;
        KWI_OFS_CAUSE: rd_data_nxt[PINS-1:0] = cause_r;
        KWI_OFS_PINS: rd_data_nxt[PINS-1:0] = key_pins;
        default: rd_data_nxt = KWI_RST_RDATA;
      endcase
    end
  end

  // read data register, valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data_r <= KWI_RST_RDATA;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // outputs
  assign rd_data = rd_data_r;
  assign irq = key_press_flag_r & key_ie_r;
  assign wake_req = wake;

  // checks

  // an enabled low pin with the function on
  sequence s_key_event;
    func_en_r && ((key_pin_enable_r & ~key_pins) != '0);
  endsequence

  // a clear of the flag by software
  sequence s_flag_clear;
    wr_status && bus_req.wdata[KWI_STAT_KEY_FLAG];
  endsequence

  // a write of the pin enables
  sequence s_pin_en_write;
    wr_pin_en;
  endsequence

  // core asleep in either low-power state
  sequence s_low_power;
    idle_mode || power_down;
  endsequence

  chk_flag_on_event: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_key_event |=> key_press_flag_r)
    else $error("flag did not set on enabled low pin");

  chk_irq_gate: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(irq) |-> ($past(any_hit) || $past(wr_mask)))
    else $error("irq rose without a key event or a mask write");

  chk_irq_after_event: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (s_key_event ##0 key_ie_r && !wr_mask) |=> irq)
    else $error("no irq one cycle after an enabled event");

  chk_flag_sticky: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (key_press_flag_r && !(wr_status && bus_req.wdata[KWI_STAT_KEY_FLAG])) |=> key_press_flag_r)
    else $error("flag dropped without software clear");

  chk_flag_clear: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (s_flag_clear ##0 !any_hit) |=> !key_press_flag_r)
    else $error("flag not cleared by write one");

  chk_set_wins: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (s_flag_clear ##0 any_hit) |=> key_press_flag_r)
    else $error("clear beat a key event in the same cycle");

  chk_wake_idle: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    ((idle_mode || power_down) && key_ie_r && key_press_flag_r) |-> wake_req)
    else $error("no wake from low power with flag set");

  chk_wake_run: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (!idle_mode && !power_down) |-> !wake_req)
    else $error("wake raised while running");

  chk_wake_live: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (s_low_power ##0 (key_ie_r && any_hit)) |-> wake_req)
    else $error("no wake from a live key in low power");

  chk_pin_enable_load: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_pin_en_write |=> key_pin_enable_r == $past(bus_req.wdata[PINS-1:0]))
    else $error("pin enable register did not load");

  chk_func_load: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wr_ctrl |=> func_en_r == $past(bus_req.wdata[KWI_CTRL_FUNC_EN]))
    else $error("function enable did not load");

  chk_mask_load: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    wr_mask |=> key_ie_r == $past(bus_req.wdata[KWI_MASK_KEY_IE]))
    else $error("interrupt enable did not load");

  chk_any_pin: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (func_en_r && (key_pin_enable_r & ~key_pins) != '0) |-> any_hit)
    else $error("selected pin did not combine into the event");

  chk_cause_set: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (pin_hit != '0) |=> (cause_r & $past(pin_hit)) == $past(pin_hit))
    else $error("cause bit missing for a live pin");

  chk_cause_sticky: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (cause_r != '0 && !wr_cause) |=> (cause_r & $past(cause_r)) == $past(cause_r))
    else $error("cause bit dropped without a clear");

  chk_func_off: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (!func_en_r && !key_press_flag_r && !(wr_ctrl && bus_req.wdata[KWI_CTRL_FUNC_EN]))
      ##1 !func_en_r |-> !key_press_flag_r)
    else $error("flag set while function disabled");

  chk_read_timing: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (bus_req.rd && bus_req.addr == KWI_OFS_PIN_EN && !wr_pin_en)
      |=> rd_data[PINS-1:0] == $past(key_pin_enable_r) ##1 (rd_data == '0 || $past(bus_req.rd)))
    else $error("read data wrong or not one cycle wide");

  chk_rd_idle: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !bus_req.rd |=> rd_data == '0)
    else $error("read data not zero outside a read");

endmodule

// ===== bench/kwi_keypad.sv
// partner model: keypad switches on port zero, a closed key pulls its pin low
// assumes the bench closes keys at a clock edge; open pins rest on their pull-ups
`timescale 1ns/10ps
module kwi_keypad
(
  // key closures from the bench
  input wire logic [7:0] key_closed,
  // port zero pins
  output logic [7:0] key_pins
);
  // an open switch leaves the pin on its pull-up, so idle reads high
  assign key_pins = ~key_closed;
endmodule

// ===== bench/tb_keypad_wake_interrupt.sv
// self-checking bench for the keypad wake interrupt: registers, flag, mask, irq, wake
// assumes kwi_top with eight pins and the kwi_keypad switch model
`timescale 1ns/10ps
module tb_keypad_wake_interrupt;
  import kwi_pkg::*;
  logic ref_clk;
  logic reset_n;
  kwi_bus_req_t bus_req;
  logic [KWI_DW-1:0] rd_data;
  logic [7:0] key_closed;
  logic [7:0] key_pins;
  logic idle_mode;
  logic power_down;
  logic irq;
  logic wake_req;
  logic [KWI_DW-1:0] got;
  int bad_count;
  int cmp_count;

  // design and switch model
  kwi_top #(.PINS(8)) u_kwi_top (.ref_clk(ref_clk), .reset_n(reset_n), .bus_req(bus_req),
    .rd_data(rd_data), .key_pins(key_pins), .idle_mode(idle_mode), .power_down(power_down),
    .irq(irq), .wake_req(wake_req));
  kwi_keypad u_kwi_keypad (.key_closed(key_closed), .key_pins(key_pins));

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // one write cycle; strobe dropped at the next edge so tasks can follow each other
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= {a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample right there
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= {a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // compare tasks, one per result width
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus_rd(a, got);
    chk32(n, e, got);
  endtask

  // close keys at an edge, then give the flag time to land
  task automatic press(input logic [7:0] k);
    @(posedge ref_clk);
    key_closed <= k;
    repeat (3) @(posedge ref_clk);
  endtask

  // let register updates reach the level outputs
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // cut a hung run short
  initial
  begin
    #200000;
    bad_count++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    bus_req = '0;
    key_closed = 8'h00;
    idle_mode = 1'b0;
    power_down = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    // reset values, and a hole in the map reads zero
    rchk("pin_en reset", KWI_OFS_PIN_EN, 32'h0000_0000);
    rchk("ctrl reset", KWI_OFS_CTRL, 32'h0000_0000);
    rchk("status reset", KWI_OFS_STATUS, 32'h0000_0000);
    rchk("mask reset", KWI_OFS_MASK, 32'h0000_0000);
    rchk("unmapped", 8'h20, 32'h0000_0000);
    bus_wr(KWI_OFS_PIN_EN, 32'h0000_00a5);
    rchk("pin_en rw", KWI_OFS_PIN_EN, 32'h0000_00a5);
    // function off: enabled low pins are ignored
    bus_wr(KWI_OFS_PIN_EN, 32'h0000_00ff);
    press(8'h08);
    rchk("flag func off", KWI_OFS_STATUS, 32'h0000_0000);
    press(8'h00);
    bus_wr(KWI_OFS_CTRL, 32'h0000_0001);
    // each pin alone: a neighbour is ignored, the pin itself sets flag and cause
    for (int n = 0; n < 8; n++)
    begin
      bus_wr(KWI_OFS_PIN_EN, 32'h0000_0001 << n);
      press(8'h01 << ((n + 1) % 8));
      rchk("flag other pin", KWI_OFS_STATUS, 32'h0000_0000);
      press(8'h01 << n);
      rchk("cause pin", KWI_OFS_CAUSE, 32'h0000_0001 << n);
      press(8'h00);
      rchk("flag held", KWI_OFS_STATUS, 32'h0000_0001);
      bus_wr(KWI_OFS_STATUS, 32'h0000_0001);
      bus_wr(KWI_OFS_CAUSE, 32'h0000_00ff);
      rchk("flag cleared", KWI_OFS_STATUS, 32'h0000_0000);
    end
    // all pins together feed one flag; the mask gates irq and wake
    bus_wr(KWI_OFS_PIN_EN, 32'h0000_00ff);
    press(8'h81);
    rchk("cause all", KWI_OFS_CAUSE, 32'h0000_0081);
    rchk("live pins", KWI_OFS_PINS, 32'h0000_007e);
    // a clear while keys are still held loses to the live event
    bus_wr(KWI_OFS_STATUS, 32'h0000_0001);
    rchk("flag set wins", KWI_OFS_STATUS, 32'h0000_0001);
    settle();
    chk1("irq masked", 1'b0, irq);
    bus_wr(KWI_OFS_MASK, 32'h0000_0001);
    settle();
    chk1("irq on", 1'b1, irq);
    @(posedge ref_clk);
    idle_mode <= 1'b1;
    settle();
    chk1("wake idle", 1'b1, wake_req);
    @(posedge ref_clk);
    idle_mode <= 1'b0;
    power_down <= 1'b1;
    settle();
    chk1("wake down", 1'b1, wake_req);
    bus_wr(KWI_OFS_MASK, 32'h0000_0000);
    settle();
    chk1("irq mask off", 1'b0, irq);
    chk1("wake mask off", 1'b0, wake_req);
    @(posedge ref_clk);
    power_down <= 1'b0;
    // release keys: only a one written to the flag clears it
    press(8'h00);
    bus_wr(KWI_OFS_MASK, 32'h0000_0001);
    bus_wr(KWI_OFS_STATUS, 32'h0000_0000);
    rchk("flag zero write", KWI_OFS_STATUS, 32'h0000_0001);
    settle();
    chk1("irq held", 1'b1, irq);
    bus_wr(KWI_OFS_STATUS, 32'h0000_0001);
    settle();
    chk1("irq cleared", 1'b0, irq);
    // a live key wakes power down before any clock edge could set the flag
    @(posedge ref_clk);
    power_down <= 1'b1;
    key_closed <= 8'h10;
    #1;
    chk1("wake live pin", 1'b1, wake_req);
    // reset in mid-run turns every setting off again, key still held
    reset_n <= 1'b0;
    @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk1("wake after reset", 1'b0, wake_req);
    rchk("pin_en reset again", KWI_OFS_PIN_EN, 32'h0000_0000);
    rchk("flag reset again", KWI_OFS_STATUS, 32'h0000_0000);
    print_verdict();
  end
endmodule
